/* shared/mmn_pkg.sv */
// constants and types for the move, multiply, negate and pop execute block
package mmn_pkg;
	localparam logic [6:0] OPC_STORE = 7'h37;
	localparam logic [6:0] OPC_NEGATE = 7'h36;
	localparam logic [6:0] OPC_MULF = 7'h01;
	localparam logic [7:0] OPC_MULL = 8'h0D;
	localparam logic [15:0] OPC_POP = 16'h0006;
	localparam logic [3:0] OPC_NOP_HI = 4'hF;
	localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
	localparam logic [3:0] ACCESS_BANK = 4'h0;
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N = 4;
	localparam logic [7:0] PROD_RESET = 8'h00;

	typedef enum logic [1:0] {
		MMN_Q1 = 2'b00,
		MMN_Q2 = 2'b01,
		MMN_Q3 = 2'b10,
		MMN_Q4 = 2'b11
	} mmn_phase_t;

	typedef enum logic [2:0] {
		MMN_OP_NONE = 3'b000,
		MMN_OP_STORE = 3'b001,
		MMN_OP_MULL = 3'b010,
		MMN_OP_MULF = 3'b011,
		MMN_OP_NEG = 3'b100,
		MMN_OP_POP = 3'b101
	} mmn_op_t;
endpackage : mmn_pkg

/* shared/mmn_dec_if.sv */
// decode results passed from decoder to executor
`timescale 1ns/1ps
`default_nettype none
interface mmn_dec_if;
	mmn_pkg::mmn_op_t op;
	logic [7:0] literal;
	logic [11:0] addr;
	logic indexed;
	modport dec (output op, output literal, output addr, output indexed);
	modport exe (input op, input literal, input addr, input indexed);
endinterface : mmn_dec_if
`default_nettype wire

/* rtl/mmn_decode.sv */
// combinational opcode decoder and file address former
`timescale 1ns/1ps
`default_nettype none
module mmn_decode (
	// instruction and banking
	input wire logic [15:0] insn_in,
	input wire logic [3:0] bank_sel_in,
	input wire logic ext_set_in,
	// decoded result
	mmn_dec_if.dec dec
);
	always_comb begin
		dec.op = mmn_pkg::MMN_OP_NONE;
		dec.literal = insn_in[7:0];
		if (insn_in == 16'h0000 || insn_in[15:12] == mmn_pkg::OPC_NOP_HI) begin
			dec.op = mmn_pkg::MMN_OP_NONE;
		end else if (insn_in == mmn_pkg::OPC_POP) begin
			dec.op = mmn_pkg::MMN_OP_POP;
		end else if (insn_in[15:9] == mmn_pkg::OPC_STORE) begin
			dec.op = mmn_pkg::MMN_OP_STORE;
		end else if (insn_in[15:9] == mmn_pkg::OPC_NEGATE) begin
			dec.op = mmn_pkg::MMN_OP_NEG;
		end else if (insn_in[15:8] == mmn_pkg::OPC_MULL) begin
			dec.op = mmn_pkg::MMN_OP_MULL;
		end else if (insn_in[15:9] == mmn_pkg::OPC_MULF) begin
			dec.op = mmn_pkg::MMN_OP_MULF;
		end
	end

	assign dec.indexed = ext_set_in && !insn_in[8]
		&& insn_in[7:0] <= mmn_pkg::INDEXED_LIMIT;

	always_comb begin
		if (insn_in[8]) begin
			dec.addr = {bank_sel_in, insn_in[7:0]};
		end else if (insn_in[7:0] < mmn_pkg::ACCESS_SPLIT) begin
			dec.addr = {mmn_pkg::ACCESS_BANK, insn_in[7:0]};
		end else begin
			dec.addr = {mmn_pkg::ACCESS_HI_BANK, insn_in[7:0]};
		end
	end
endmodule : mmn_decode
`default_nettype wire

/* rtl/mmn_exec.sv */
// four-phase execute unit for store, multiply, negate and pop
`timescale 1ns/1ps
`default_nettype none
module mmn_exec (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// instruction stream
	input wire logic [15:0] insn_in,
	input wire logic insn_valid_in,
	// core state
	input wire logic [7:0] work_in,
	input wire logic [3:0] bank_sel_in,
	input wire logic ext_set_in,
	input wire logic [4:0] status_in,
	// file read
	output logic [11:0] rd_addr_out,
	output logic rd_indexed_out,
	output logic rd_en_out,
	input wire logic [7:0] rd_data_in,
	// file write
	output logic [11:0] wr_addr_out,
	output logic wr_indexed_out,
	output logic [7:0] wr_data_out,
	output logic wr_en_out,
	// status write
	output logic [4:0] status_out,
	output logic status_we_out,
	// product and stack
	output logic [7:0] product_high_register_out,
	output logic [7:0] product_low_register_out,
	output logic stack_pop_out,
	// phase
	output logic [1:0] phase_out,
	output logic busy_out
);
	mmn_dec_if dif ();
	mmn_pkg::mmn_phase_t phase_ff;
	mmn_pkg::mmn_op_t op_ff;
	logic [7:0] lit_ff;
	logic [11:0] addr_ff;
	logic idx_ff;
	logic active_ff;
	logic [7:0] opnd_ff;
	logic [15:0] res_ff;
	logic [4:0] flags_ff;
	logic [7:0] prod_hi_ff;
	logic [7:0] prod_lo_ff;
	logic [7:0] neg_val;
	logic [4:0] nxt_flags;

	mmn_decode u_dec (
		.insn_in(insn_in),
		.bank_sel_in(bank_sel_in),
		.ext_set_in(ext_set_in),
		.dec(dif)
	);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			phase_ff <= mmn_pkg::MMN_Q1;
			active_ff <= 1'b0;
		end else begin
			case (phase_ff)
				mmn_pkg::MMN_Q1: begin
					phase_ff <= mmn_pkg::MMN_Q2;
					active_ff <= insn_valid_in;
				end
				mmn_pkg::MMN_Q2: phase_ff <= mmn_pkg::MMN_Q3;
				mmn_pkg::MMN_Q3: phase_ff <= mmn_pkg::MMN_Q4;
				mmn_pkg::MMN_Q4: begin
					phase_ff <= mmn_pkg::MMN_Q1;
					active_ff <= 1'b0;
				end
				default: phase_ff <= mmn_pkg::MMN_Q1;
			endcase
		end
	end

	// decoded instruction captured in the decode phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			op_ff <= mmn_pkg::MMN_OP_NONE;
			lit_ff <= 8'h00;
			addr_ff <= 12'h000;
			idx_ff <= 1'b0;
		end else if (phase_ff == mmn_pkg::MMN_Q1) begin
			op_ff <= insn_valid_in ? dif.op : mmn_pkg::MMN_OP_NONE;
			lit_ff <= dif.literal;
			addr_ff <= dif.addr;
			idx_ff <= dif.indexed;
		end
	end

	// operand read phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			opnd_ff <= 8'h00;
		end else if (phase_ff == mmn_pkg::MMN_Q2) begin
			case (op_ff)
				mmn_pkg::MMN_OP_MULL: opnd_ff <= lit_ff;
				mmn_pkg::MMN_OP_STORE: opnd_ff <= work_in;
				default: opnd_ff <= rd_data_in;
			endcase
		end
	end

	assign neg_val = 8'(~opnd_ff + 8'h01);

	always_comb begin
		nxt_flags = status_in;
		nxt_flags[mmn_pkg::FLAG_N] = neg_val[7];
		nxt_flags[mmn_pkg::FLAG_Z] = (neg_val == 8'h00);
		nxt_flags[mmn_pkg::FLAG_C] = (opnd_ff == 8'h00);
		nxt_flags[mmn_pkg::FLAG_DC] = (opnd_ff[3:0] == 4'h0);
		nxt_flags[mmn_pkg::FLAG_OV] = (opnd_ff == 8'h80);
	end

	// process phase
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			res_ff <= 16'h0000;
			flags_ff <= 5'h00;
		end else if (phase_ff == mmn_pkg::MMN_Q3) begin
			case (op_ff)
				mmn_pkg::MMN_OP_MULL, mmn_pkg::MMN_OP_MULF:
					res_ff <= 16'(work_in) * 16'(opnd_ff);
				mmn_pkg::MMN_OP_NEG: begin
					res_ff <= {8'h00, neg_val};
					flags_ff <= nxt_flags;
				end
				default: res_ff <= {8'h00, opnd_ff};
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			prod_hi_ff <= mmn_pkg::PROD_RESET;
			prod_lo_ff <= mmn_pkg::PROD_RESET;
		end else if (phase_ff == mmn_pkg::MMN_Q4 && active_ff
			&& (op_ff == mmn_pkg::MMN_OP_MULL
			|| op_ff == mmn_pkg::MMN_OP_MULF)) begin
			prod_hi_ff <= res_ff[15:8];
			prod_lo_ff <= res_ff[7:0];
		end
	end

	assign product_high_register_out = prod_hi_ff;
	assign product_low_register_out = prod_lo_ff;

	// file multiply reads but never writes
	assign rd_en_out = active_ff && phase_ff == mmn_pkg::MMN_Q2
		&& (op_ff == mmn_pkg::MMN_OP_MULF || op_ff == mmn_pkg::MMN_OP_NEG);
	assign rd_addr_out = addr_ff;
	assign rd_indexed_out = idx_ff;

	assign wr_en_out = active_ff && phase_ff == mmn_pkg::MMN_Q4
		&& (op_ff == mmn_pkg::MMN_OP_STORE || op_ff == mmn_pkg::MMN_OP_NEG);
	assign wr_addr_out = addr_ff;
	assign wr_indexed_out = idx_ff;
	assign wr_data_out = res_ff[7:0];

	assign status_we_out = active_ff && phase_ff == mmn_pkg::MMN_Q4
		&& op_ff == mmn_pkg::MMN_OP_NEG;
	assign status_out = flags_ff;

	assign stack_pop_out = active_ff && phase_ff == mmn_pkg::MMN_Q3
		&& op_ff == mmn_pkg::MMN_OP_POP;

	assign phase_out = phase_ff;
	assign busy_out = active_ff;

	// assertions
	sequence s_mul_q3;
		phase_ff == mmn_pkg::MMN_Q3 && active_ff
			&& (op_ff == mmn_pkg::MMN_OP_MULL || op_ff == mmn_pkg::MMN_OP_MULF);
	endsequence

	a_mul_prod_pair: assert property (@(posedge clk_in) disable iff (rst_in)
		s_mul_q3 ##1 1'b1 |=> {prod_hi_ff, prod_lo_ff} == $past(res_ff))
		else $error("product pair not loaded");
	a_mul_value: assert property (@(posedge clk_in) disable iff (rst_in)
		s_mul_q3 |=> res_ff == $past(work_in) * $past(opnd_ff))
		else $error("product value wrong");
	a_mul_no_flags: assert property (@(posedge clk_in) disable iff (rst_in)
		(op_ff == mmn_pkg::MMN_OP_MULF || op_ff == mmn_pkg::MMN_OP_MULL)
			|-> !status_we_out)
		else $error("multiply wrote flags");
	a_mulf_no_write: assert property (@(posedge clk_in) disable iff (rst_in)
		op_ff == mmn_pkg::MMN_OP_MULF |-> !wr_en_out)
		else $error("file multiply wrote file");
	a_store_data: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_en_out && op_ff == mmn_pkg::MMN_OP_STORE
			|-> wr_data_out == $past(work_in, 2) && !status_we_out)
		else $error("store data wrong");
	a_neg_value: assert property (@(posedge clk_in) disable iff (rst_in)
		wr_en_out && op_ff == mmn_pkg::MMN_OP_NEG
			|-> wr_data_out + opnd_ff == 8'h00 && status_we_out)
		else $error("negate result wrong");
	a_pop_phase: assert property (@(posedge clk_in) disable iff (rst_in)
		stack_pop_out |-> phase_ff == mmn_pkg::MMN_Q3 ##1 !stack_pop_out[*3])
		else $error("pop not single phase three pulse");
	a_phase_cycle: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_ff == mmn_pkg::MMN_Q1 |=> phase_ff == mmn_pkg::MMN_Q2
			##1 phase_ff == mmn_pkg::MMN_Q3 ##1 phase_ff == mmn_pkg::MMN_Q4)
		else $error("phase order broken");
	a_nop_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
		phase_ff == mmn_pkg::MMN_Q1 && insn_in == 16'h0000
			|=> ##2 !wr_en_out && !status_we_out && !stack_pop_out)
		else $error("no-operation changed state");
	a_bank_addr: assert property (@(posedge clk_in) disable iff (rst_in)
		insn_in[8] |-> dif.addr == {bank_sel_in, insn_in[7:0]})
		else $error("bank select address wrong");
	a_indexed: assert property (@(posedge clk_in) disable iff (rst_in)
		dif.indexed |-> ext_set_in && !insn_in[8] && insn_in[7:0] <= 8'h5F)
		else $error("indexed mode misapplied");
	a_bank_reach: assert property (@(posedge clk_in) disable iff (rst_in)
		dif.addr[7:0] == insn_in[7:0])
		else $error("file offset truncated");
endmodule : mmn_exec
`default_nettype wire

/* verif/mmn_file_model.sv */
// data register file model on the far side of the execute block
`timescale 1ns/1ps
`default_nettype none
module mmn_file_model (
	// clock
	input wire logic clk_in,
	// read side
	input wire logic [11:0] rd_addr_in,
	input wire logic rd_en_in,
	output logic [7:0] rd_data_out,
	// write side
	input wire logic [11:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_en_in
);
	logic [7:0] mem [4096];
	logic [7:0] last_ff = 8'h5A;
	always_comb begin
		rd_data_out = rd_en_in ? mem[rd_addr_in] : ~last_ff;
	end
	always @(posedge clk_in) begin
		if (rd_en_in) begin
			last_ff <= mem[rd_addr_in];
		end
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
	end
endmodule : mmn_file_model
`default_nettype wire

/* verif/mmn_exec_tb.sv */
// self-checking bench for the execute block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module mmn_exec_tb;
	logic clk_in, rst_in, insn_valid_in, ext_set_in, rd_indexed_out;
	logic rd_en_out, wr_indexed_out, wr_en_out, status_we_out;
	logic stack_pop_out, busy_out, rdi, wri;
	logic [15:0] insn_in;
	logic [7:0] work_in, rd_data_in, wr_data_out, ph, pl, wrd;
	logic [3:0] bank_sel_in, rdv, popv, wrv, swev, bsv;
	logic [4:0] status_in, status_out, st;
	logic [11:0] rd_addr_out, wr_addr_out, rda, wra;
	logic [1:0] phase_out;
	int err_total = 0;
	int checked = 0;
	mmn_exec dut (.clk_in(clk_in), .rst_in(rst_in), .insn_in(insn_in),
		.insn_valid_in(insn_valid_in), .work_in(work_in),
		.bank_sel_in(bank_sel_in), .ext_set_in(ext_set_in),
		.status_in(status_in), .rd_addr_out(rd_addr_out),
		.rd_indexed_out(rd_indexed_out), .rd_en_out(rd_en_out),
		.rd_data_in(rd_data_in), .wr_addr_out(wr_addr_out),
		.wr_indexed_out(wr_indexed_out), .wr_data_out(wr_data_out),
		.wr_en_out(wr_en_out), .status_out(status_out),
		.status_we_out(status_we_out), .product_high_register_out(ph),
		.product_low_register_out(pl), .stack_pop_out(stack_pop_out),
		.phase_out(phase_out), .busy_out(busy_out));
	mmn_file_model u_file (.clk_in(clk_in), .rd_addr_in(rd_addr_out),
		.rd_en_in(rd_en_out), .rd_data_out(rd_data_in),
		.wr_addr_in(wr_addr_out), .wr_data_in(wr_data_out),
		.wr_en_in(wr_en_out));
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	task close_out;
		if (err_total == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out
	// one instruction, pop opcode held outside the decode phase
	task automatic run(input logic [15:0] insn, input logic [7:0] w);
		insn_in = insn;
		work_in = w;
		insn_valid_in = 1'b1;
		@(posedge clk_in);
		#1;
		insn_in = 16'h0006;
		for (int i = 0; i < 4; i++) begin
			rdv[i] = rd_en_out;
			popv[i] = stack_pop_out;
			wrv[i] = wr_en_out;
			swev[i] = status_we_out;
			bsv[i] = busy_out;
			if (i == 0) begin
				rda = rd_addr_out;
				rdi = rd_indexed_out;
			end
			if (i == 2) begin
				{wra, wri, wrd, st} = {wr_addr_out, wr_indexed_out,
					wr_data_out, status_out};
			end
			`CHK(phase_out, 2'(i + 1))
			if (i < 3) begin
				@(posedge clk_in);
				#1;
			end
		end
		insn_valid_in = 1'b0;
	endtask : run
	task automatic strobes(input logic [15:0] e);
		`CHK({rdv, popv, wrv, swev}, e)
		`CHK(bsv, 4'h7)
	endtask : strobes
	task automatic st1(input logic [15:0] i, input logic [11:0] a,
		input logic x);
		run(i, 8'h4F);
		strobes(16'h0040);
		`CHK({wra, wri, wrd}, {a, x, 8'h4F})
	endtask : st1
	task automatic t_store;
		bank_sel_in = 4'h5;
		st1(16'h6E20, 12'h020, 1'b0);
		st1(16'h6E80, 12'hF80, 1'b0);
		st1(16'h6FFF, 12'h5FF, 1'b0);
		ext_set_in = 1'b1;
		st1(16'h6E5F, 12'h05F, 1'b1);
		st1(16'h6E60, 12'hF60, 1'b0);
		st1(16'h6F10, 12'h510, 1'b0);
		ext_set_in = 1'b0;
	endtask : t_store
	task automatic t_mul;
		run(16'h0DC4, 8'hE2);
		strobes(16'h0000);
		`CHK({ph, pl}, 16'hAD08)
		u_file.mem[12'h520] = 8'hB5;
		run(16'h0320, 8'hC4);
		strobes(16'h1000);
		`CHK({rda, rdi, ph, pl}, {12'h520, 1'b0, 16'h8A94})
		`CHK(u_file.mem[12'h520], 8'hB5)
		ext_set_in = 1'b1;
		u_file.mem[12'h010] = 8'h00;
		run(16'h0210, 8'hFF);
		strobes(16'h1000);
		`CHK({rda, rdi, ph, pl}, {12'h010, 1'b1, 16'h0000})
		ext_set_in = 1'b0;
	endtask : t_mul
	task automatic t_neg;
		logic [7:0] ops [4] = '{8'h3A, 8'h00, 8'h80, 8'hFF};
		logic [7:0] e;
		logic [4:0] f;
		foreach (ops[i]) begin
			u_file.mem[12'h530] = ops[i];
			e = 8'(~ops[i] + 8'h01);
			f = {e[7], ops[i] == 8'h80, e == 8'h00, ops[i][3:0] == 4'h0,
				ops[i] == 8'h00};
			run(16'h6D30, 8'h00);
			strobes(16'h1044);
			`CHK({rda, wra, wrd, st}, {12'h530, 12'h530, e, f})
			`CHK(u_file.mem[12'h530], e)
		end
	endtask : t_neg
	task automatic t_pop_nop;
		run(16'h0D03, 8'h55);
		`CHK({ph, pl}, 16'h00FF)
		run(16'h0006, 8'h11);
		strobes(16'h0200);
		run(16'h0000, 8'h22);
		`CHK({rdv, popv, wrv, swev, ph, pl}, 32'h000000FF)
		run(16'hF123, 8'h33);
		`CHK({rdv, popv, wrv, swev, ph, pl}, 32'h000000FF)
	endtask : t_pop_nop
	initial begin
		#80000;
		err_total++;
		close_out();
	end
	initial begin
		{rst_in, insn_valid_in, ext_set_in} = 3'h4;
		{insn_in, work_in, bank_sel_in, status_in} = {16'h0, 8'h0, 4'h0, 5'h15};
		repeat (2) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		`CHK({ph, pl, phase_out, busy_out, rd_en_out, wr_en_out}, 21'h0)
		t_store();
		t_mul();
		t_neg();
		t_pop_nop();
		close_out();
	end
endmodule : mmn_exec_tb
`default_nettype wire
